//--- sbp_defines.svh
// offsets, field positions, reset values and timing counts of the strobed parallel port
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH
// ******************************
// register byte offsets
// ******************************
`define SBP_OFS_PORT_A 8'h00
`define SBP_OFS_PORT_B 8'h04
`define SBP_OFS_PORT_C 8'h08
`define SBP_OFS_CTRL 8'h0C
// ******************************
// control word fields
// ******************************
`define SBP_CW_MODESET 7
`define SBP_CW_A_BIDIR 6
`define SBP_CW_A_STROBED 5
`define SBP_CW_A_DIR 4
`define SBP_CW_CU_DIR 3
`define SBP_CW_B_MODE 2
`define SBP_CW_B_DIR 1
`define SBP_CW_CL_DIR 0
`define SBP_BSR_SEL_HI 3
`define SBP_BSR_SEL_LO 1
`define SBP_BSR_VAL 0
// ******************************
// port C line positions
// ******************************
`define SBP_PC_A_FULL_N 7
`define SBP_PC_A_RET 6
`define SBP_PC_A_IN_FULL 5
`define SBP_PC_A_STROBE 4
`define SBP_PC_A_IRQ 3
`define SBP_PC_B_STROBE 2
`define SBP_PC_B_FULL 1
`define SBP_PC_B_IRQ 0
`define SBP_PC_LOW_WR_MASK 8'h07
// ******************************
// reset values and bus answers
// ******************************
`define SBP_CTRL_RST 8'h9B
`define SBP_RESP_OKAY 2'h0
`define SBP_RESP_SLVERR 2'h2
// ******************************
// reset timing kept by the controlling party
// ******************************
`define SBP_CLK_NS 40
`define SBP_RST_PWR_US 50
`define SBP_RST_PWR_CYC ((`SBP_RST_PWR_US * 1000 + `SBP_CLK_NS - 1) / `SBP_CLK_NS)
`define SBP_RST_PULSE_NS 500
`define SBP_RST_PULSE_CYC ((`SBP_RST_PULSE_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)
`endif

//--- sbp_periph.sv
// peripheral model: strobes bytes in, takes back written bytes
`timescale 1ns/10ps
module sbp_periph (
    input wire logic mclk_i,
    input wire logic [7:0] dev_pa_i,
    input wire logic dev_pa_oe_i,
    output logic [7:0] pa_pin_o,
    output logic ret_n_o,
    output logic strobe_n_o
);
    logic [7:0] drv = 8'hA5;
    // released bus shows the inverse of the last byte, never a stale copy
    assign pa_pin_o = dev_pa_oe_i ? dev_pa_i : drv;
    initial begin
        ret_n_o = 1'b1;
        strobe_n_o = 1'b1;
    end
    // present a byte and pulse the strobe low
    task automatic put(input logic [7:0] d);
        drv <= d;
        strobe_n_o <= 1'b0;
        repeat (6) @(posedge mclk_i);
        strobe_n_o <= 1'b1;
        repeat (2) @(posedge mclk_i);
        drv <= ~d;
    endtask
    // hold return low and take what the port drives
    task automatic take(output logic [7:0] q);
        ret_n_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
        q = pa_pin_o;
        ret_n_o <= 1'b1;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule

//--- sbp_pkg.sv
// types shared by the strobed parallel port
package sbp_pkg;
    // group A operating modes
    typedef enum logic [1:0] {
        SBP_A_BASIC = 2'b00,
        SBP_A_STROBED = 2'b01,
        SBP_A_BIDIR = 2'b10
    } sbp_amode_t;
endpackage

//--- sbp_port_top.sv
// strobed bidirectional parallel port with an AXI4-Lite register slave
`timescale 1ns/10ps
`include "sbp_defines.svh"
// Contract
// - write drops out-full, return fall raises it
// - written byte held, port A stays undriven
// - return low drives port A from latch
// - input strobe low captures port A pins
// - strobe fall sets in-full, read clears
// - two group A masks via bits 6,4
// - bidir uses port C 7..3, B uses 2..0
// - spare port C direction by bits 3,0
// - strobed groups claim their fixed port C lines
// - upper spares bit-set only, lower byte-writable
// - bit set/reset always works on port C bits 7..0
// - port C read shows live handshake status
// - status read layout per mode combination
// - control word write clears port output latches, not input latches
// - port B clear on control write is optional
// - group B never takes bidirectional mode
// - input irq on strobe rise, cleared by read
// - output irq on return rise, cleared by write
module sbp_port_top import sbp_pkg::*; #(
    parameter int AW = 8,
    parameter bit CLEAR_PORT_B = 1'b1
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [7:0] pa_i,
    output logic [7:0] pa_o,
    output logic pa_oe_o,
    input wire logic [7:0] pb_i,
    output logic [7:0] pb_o,
    output logic pb_oe_o,
    input wire logic [7:0] pc_i,
    output logic [7:0] pc_o,
    output logic [7:0] pc_oe_o
);
    if (AW < 5) begin : g_chk
        $error("sbp_port_top: AW must be at least 5");
    end

    // ******************************
    // bus slave
    // ******************************
    logic [AW-1:0] waddr, next_waddr;
    logic [7:0] wbyte, next_wbyte;
    logic wlane, next_wlane;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_fire, rd_fire, wr_hit, rd_hit;
    logic [7:0] rd_val;
    logic [AW-1:0] wa, ra;

    // address and data may come in either order; one write at a time
    always_comb begin
        next_waddr = waddr;
        next_wbyte = wbyte;
        next_wlane = wlane;
        next_awready = s_axi_awready_o;
        next_wready = s_axi_wready_o;
        next_bvalid = s_axi_bvalid_o;
        next_bresp = s_axi_bresp_o;
        next_arready = s_axi_arready_o;
        next_rvalid = s_axi_rvalid_o;
        next_rdata = s_axi_rdata_o;
        next_rresp = s_axi_rresp_o;
        wa = {waddr[AW-1:2], 2'b00};
        ra = {s_axi_araddr_i[AW-1:2], 2'b00};
        wr_hit = (wa == AW'(`SBP_OFS_PORT_A)) || (wa == AW'(`SBP_OFS_PORT_B))
            || (wa == AW'(`SBP_OFS_PORT_C)) || (wa == AW'(`SBP_OFS_CTRL));
        rd_hit = (ra == AW'(`SBP_OFS_PORT_A)) || (ra == AW'(`SBP_OFS_PORT_B))
            || (ra == AW'(`SBP_OFS_PORT_C)) || (ra == AW'(`SBP_OFS_CTRL));
        wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
        rd_fire = s_axi_arvalid_i && s_axi_arready_o;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_waddr = s_axi_awaddr_i;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_wbyte = s_axi_wdata_i[7:0];
            next_wlane = s_axi_wstrb_i[0];
            next_wready = 1'b0;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? `SBP_RESP_OKAY : `SBP_RESP_SLVERR;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_arready = 1'b0;
            next_rdata = {24'h000000, rd_val};
            next_rresp = rd_hit ? `SBP_RESP_OKAY : `SBP_RESP_SLVERR;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            waddr <= '0;
            wbyte <= 8'h00;
            wlane <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `SBP_RESP_OKAY;
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `SBP_RESP_OKAY;
        end else begin
            waddr <= next_waddr;
            wbyte <= next_wbyte;
            wlane <= next_wlane;
            s_axi_awready_o <= next_awready;
            s_axi_wready_o <= next_wready;
            s_axi_bvalid_o <= next_bvalid;
            s_axi_bresp_o <= next_bresp;
            s_axi_arready_o <= next_arready;
            s_axi_rvalid_o <= next_rvalid;
            s_axi_rdata_o <= next_rdata;
            s_axi_rresp_o <= next_rresp;
        end
    end

    // ******************************
    // pin strobes
    // ******************************
    logic [7:0] pc_lvl, pc_fall, pc_rise;

    // async peripheral strobes never touch flags unsynchronised
    sbp_sync_edge #(.WIDTH(8)) u_pc_sync (
        .clk_i(mclk_i),
        .rst_i(sys_rst_i),
        .d_i(pc_i),
        .lvl_o(pc_lvl),
        .fall_o(pc_fall),
        .rise_o(pc_rise)
    );

    // ******************************
    // port state
    // ******************************
    logic [7:0] ctrl, pa_latch, pa_in_latch, pb_latch, pb_in_latch, pc_latch;
    logic grp_a_out_full_n, grp_a_in_full, irq_in_pend, irq_out_pend;
    logic output_irq_mask, input_irq_mask;
    logic grp_b_out_full_n, grp_b_in_full, grp_b_irq_pend, grp_b_irq_mask;
    logic [7:0] next_ctrl, next_pa_latch, next_pa_in_latch, next_pb_latch;
    logic [7:0] next_pb_in_latch, next_pc_latch, next_pa_o, next_pb_o, next_pc_o;
    logic [7:0] next_pc_oe, pc_rd, pc_wmask;
    logic next_a_full_n, next_a_in_full, next_irq_in, next_irq_out;
    logic next_out_mask, next_in_mask, next_b_full_n, next_b_in_full;
    logic next_b_irq, next_b_mask, next_pa_oe, next_pb_oe;
    sbp_amode_t a_mode;
    logic a_hs, b_hs, a_in_side, a_out_side, irq_a, irq_b;
    logic wr_a, wr_b, wr_c, cw_wr, bsr_wr, rd_a, rd_b;
    logic [2:0] bsr_sel;

    always_comb begin
        // group B has a one-bit mode field, so bidir is unreachable
        a_mode = ctrl[`SBP_CW_A_BIDIR] ? SBP_A_BIDIR
            : (ctrl[`SBP_CW_A_STROBED] ? SBP_A_STROBED : SBP_A_BASIC);
        b_hs = ctrl[`SBP_CW_B_MODE];
        a_hs = (a_mode != SBP_A_BASIC);
        a_in_side = (a_mode == SBP_A_BIDIR)
            || (a_mode == SBP_A_STROBED && ctrl[`SBP_CW_A_DIR]);
        a_out_side = (a_mode == SBP_A_BIDIR)
            || (a_mode == SBP_A_STROBED && !ctrl[`SBP_CW_A_DIR]);
        // single request line ORs both masked sides
        irq_a = (a_in_side && irq_in_pend && input_irq_mask)
            || (a_out_side && irq_out_pend && output_irq_mask);
        irq_b = b_hs && grp_b_irq_pend && grp_b_irq_mask;
        wr_a = wr_fire && wlane && (wa == AW'(`SBP_OFS_PORT_A));
        wr_b = wr_fire && wlane && (wa == AW'(`SBP_OFS_PORT_B));
        wr_c = wr_fire && wlane && (wa == AW'(`SBP_OFS_PORT_C));
        cw_wr = wr_fire && wlane && (wa == AW'(`SBP_OFS_CTRL)) && wbyte[`SBP_CW_MODESET];
        bsr_wr = wr_fire && wlane && (wa == AW'(`SBP_OFS_CTRL)) && !wbyte[`SBP_CW_MODESET];
        bsr_sel = wbyte[`SBP_BSR_SEL_HI:`SBP_BSR_SEL_LO];
        rd_a = rd_fire && (ra == AW'(`SBP_OFS_PORT_A));
        rd_b = rd_fire && (ra == AW'(`SBP_OFS_PORT_B));
        // spare port C lines follow the direction bits
        next_pc_oe = {{4{!ctrl[`SBP_CW_CU_DIR]}}, {4{!ctrl[`SBP_CW_CL_DIR]}}};
        next_pc_o = pc_latch;
        // claimed lines per mode
        unique case (a_mode)
            SBP_A_BASIC: begin
            end
            SBP_A_STROBED: begin
                next_pc_o[`SBP_PC_A_IRQ] = irq_a;
                next_pc_oe[`SBP_PC_A_IRQ] = 1'b1;
                if (ctrl[`SBP_CW_A_DIR]) begin
                    next_pc_o[`SBP_PC_A_IN_FULL] = grp_a_in_full;
                    next_pc_oe[`SBP_PC_A_IN_FULL] = 1'b1;
                    next_pc_oe[`SBP_PC_A_STROBE] = 1'b0;
                end else begin
                    next_pc_o[`SBP_PC_A_FULL_N] = grp_a_out_full_n;
                    next_pc_oe[`SBP_PC_A_FULL_N] = 1'b1;
                    next_pc_oe[`SBP_PC_A_RET] = 1'b0;
                end
            end
            SBP_A_BIDIR: begin
                next_pc_o[7:3] = {grp_a_out_full_n, 1'b0, grp_a_in_full, 1'b0, irq_a};
                next_pc_oe[7:3] = 5'b10101;
            end
            default: begin
            end
        endcase
        if (b_hs) begin
            next_pc_o[`SBP_PC_B_FULL] = ctrl[`SBP_CW_B_DIR] ? grp_b_in_full : grp_b_out_full_n;
            next_pc_o[`SBP_PC_B_IRQ] = irq_b;
            next_pc_oe[2:0] = 3'b011;
        end
        // live status replaces pins on handshake positions
        for (int i = 0; i < 8; i++) begin
            pc_rd[i] = next_pc_oe[i] ? pc_latch[i] : pc_i[i];
        end
        if (a_mode == SBP_A_BIDIR) begin
            pc_rd[7:3] = {grp_a_out_full_n, output_irq_mask, grp_a_in_full,
                input_irq_mask, irq_a};
        end else if (a_in_side) begin
            pc_rd[5:3] = {grp_a_in_full, input_irq_mask, irq_a};
        end else if (a_out_side) begin
            pc_rd[7:6] = {grp_a_out_full_n, output_irq_mask};
            pc_rd[3] = irq_a;
        end
        if (b_hs) begin
            pc_rd[2:0] = {grp_b_irq_mask, next_pc_o[`SBP_PC_B_FULL], irq_b};
        end
        // input data only reaches the bus during a read
        if (ra == AW'(`SBP_OFS_PORT_A)) begin
            rd_val = a_in_side ? pa_in_latch : (ctrl[`SBP_CW_A_DIR] ? pa_i : pa_latch);
        end else if (ra == AW'(`SBP_OFS_PORT_B)) begin
            rd_val = (b_hs && ctrl[`SBP_CW_B_DIR]) ? pb_in_latch
                : (ctrl[`SBP_CW_B_DIR] ? pb_i : pb_latch);
        end else if (ra == AW'(`SBP_OFS_PORT_C)) begin
            rd_val = pc_rd;
        end else if (ra == AW'(`SBP_OFS_CTRL)) begin
            rd_val = ctrl;
        end else begin
            rd_val = 8'h00;
        end
        // port A drives only while return is low in bidir
        next_pa_oe = (a_mode == SBP_A_BIDIR) ? !pc_lvl[`SBP_PC_A_RET] : !ctrl[`SBP_CW_A_DIR];
        next_pa_o = pa_latch;
        next_pb_oe = !ctrl[`SBP_CW_B_DIR];
        next_pb_o = pb_latch;
    end

    // handshake flags; hardware sets beat same-cycle read/write clears except out-full, where the write wins; mode set beats all
    always_comb begin
        next_ctrl = ctrl;
        next_pa_latch = wr_a ? wbyte : pa_latch;
        next_pb_latch = wr_b ? wbyte : pb_latch;
        // upper spares only via bit set/reset once any handshake runs
        pc_wmask = (a_hs || b_hs) ? `SBP_PC_LOW_WR_MASK : 8'hFF;
        next_pc_latch = wr_c ? ((pc_latch & ~pc_wmask) | (wbyte & pc_wmask)) : pc_latch;
        next_pa_in_latch = pa_in_latch;
        next_pb_in_latch = pb_in_latch;
        next_a_full_n = grp_a_out_full_n;
        next_a_in_full = grp_a_in_full;
        next_irq_in = irq_in_pend;
        next_irq_out = irq_out_pend;
        next_out_mask = output_irq_mask;
        next_in_mask = input_irq_mask;
        next_b_full_n = grp_b_out_full_n;
        next_b_in_full = grp_b_in_full;
        next_b_irq = grp_b_irq_pend;
        next_b_mask = grp_b_irq_mask;
        if (a_out_side) begin
            if (wr_a) next_a_full_n = 1'b0;
            else if (pc_fall[`SBP_PC_A_RET]) next_a_full_n = 1'b1;
            if (pc_rise[`SBP_PC_A_RET] && output_irq_mask) next_irq_out = 1'b1;
            else if (wr_a) next_irq_out = 1'b0;
        end
        if (a_in_side) begin
            if (pc_fall[`SBP_PC_A_STROBE]) begin
                next_pa_in_latch = pa_i;
                next_a_in_full = 1'b1;
            end else if (rd_a) begin
                next_a_in_full = 1'b0;
            end
            if (pc_rise[`SBP_PC_A_STROBE] && grp_a_in_full && input_irq_mask) begin
                next_irq_in = 1'b1;
            end else if (rd_a) begin
                next_irq_in = 1'b0;
            end
        end
        // group B shares one strobe/return line on bit 2
        if (b_hs && ctrl[`SBP_CW_B_DIR]) begin
            if (pc_fall[`SBP_PC_B_STROBE]) begin
                next_pb_in_latch = pb_i;
                next_b_in_full = 1'b1;
            end else if (rd_b) begin
                next_b_in_full = 1'b0;
            end
            if (pc_rise[`SBP_PC_B_STROBE] && grp_b_in_full && grp_b_irq_mask) next_b_irq = 1'b1;
            else if (rd_b) next_b_irq = 1'b0;
        end else if (b_hs) begin
            if (wr_b) next_b_full_n = 1'b0;
            else if (pc_fall[`SBP_PC_B_STROBE]) next_b_full_n = 1'b1;
            if (pc_rise[`SBP_PC_B_STROBE] && grp_b_irq_mask) next_b_irq = 1'b1;
            else if (wr_b) next_b_irq = 1'b0;
        end
        // single-bit commands reach every port C bit; masks sit on 6, 4 and 2
        if (bsr_wr) begin
            next_pc_latch[bsr_sel] = wbyte[`SBP_BSR_VAL];
            if (bsr_sel == 3'd6) next_out_mask = wbyte[`SBP_BSR_VAL];
            if (bsr_sel == 3'd4) next_in_mask = wbyte[`SBP_BSR_VAL];
            if (bsr_sel == 3'd2) next_b_mask = wbyte[`SBP_BSR_VAL];
        end
        // mode set clears output latches and handshake state; input capture latches keep their value
        if (cw_wr) begin
            next_ctrl = wbyte;
            next_pa_latch = 8'h00;
            next_pc_latch = 8'h00;
            next_pb_latch = CLEAR_PORT_B ? 8'h00 : pb_latch;
            next_a_full_n = 1'b1;
            next_a_in_full = 1'b0;
            next_irq_in = 1'b0;
            next_irq_out = 1'b0;
            next_out_mask = 1'b0;
            next_in_mask = 1'b0;
            next_b_full_n = 1'b1;
            next_b_in_full = 1'b0;
            next_b_irq = 1'b0;
            next_b_mask = 1'b0;
        end
    end

    // reset leaves every port an input
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= `SBP_CTRL_RST;
            {pa_latch, pa_in_latch, pb_latch, pb_in_latch, pc_latch} <= 40'h0000000000;
            {grp_a_out_full_n, grp_b_out_full_n} <= 2'b11;
            {grp_a_in_full, irq_in_pend, irq_out_pend, output_irq_mask} <= 4'h0;
            {input_irq_mask, grp_b_in_full, grp_b_irq_pend, grp_b_irq_mask} <= 4'h0;
            {pa_o, pb_o, pc_o, pc_oe_o} <= 32'h00000000;
            {pa_oe_o, pb_oe_o} <= 2'b00;
        end else begin
            ctrl <= next_ctrl;
            {pa_latch, pa_in_latch, pb_latch} <= {next_pa_latch, next_pa_in_latch, next_pb_latch};
            {pb_in_latch, pc_latch} <= {next_pb_in_latch, next_pc_latch};
            {grp_a_out_full_n, grp_b_out_full_n} <= {next_a_full_n, next_b_full_n};
            {grp_a_in_full, irq_in_pend, irq_out_pend} <= {next_a_in_full, next_irq_in, next_irq_out};
            {output_irq_mask, input_irq_mask} <= {next_out_mask, next_in_mask};
            {grp_b_in_full, grp_b_irq_pend, grp_b_irq_mask} <= {next_b_in_full, next_b_irq, next_b_mask};
            {pa_o, pb_o, pc_o, pc_oe_o} <= {next_pa_o, next_pb_o, next_pc_o, next_pc_oe};
            {pa_oe_o, pb_oe_o} <= {next_pa_oe, next_pb_oe};
        end
    end

    // ******************************
    // checks
    // ******************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    out_full_drop_a: assert property (wr_a && a_out_side |=> !grp_a_out_full_n)
        else $error("out-full not dropped after port A write");
    out_full_rise_a: assert property (a_out_side && pc_fall[6] && !wr_a
        |=> grp_a_out_full_n) else $error("out-full not raised by return fall");
    pa_hiz_a: assert property (a_mode == SBP_A_BIDIR && pc_lvl[6] |=> !pa_oe_o)
        else $error("port A driven while return high");
    pa_drive_a: assert property (a_mode == SBP_A_BIDIR && !pc_lvl[6]
        |=> pa_oe_o && pa_o == $past(pa_latch))
        else $error("port A not driving latch while return low");
    in_full_set_a: assert property (a_in_side && pc_fall[4] && !cw_wr
        |=> grp_a_in_full && pa_in_latch == $past(pa_i))
        else $error("in-full or capture missing after strobe fall");
    in_full_clr_a: assert property (rd_a && !pc_fall[4] && !cw_wr
        |=> !grp_a_in_full) else $error("in-full not cleared by read");
    irq_in_a: assert property (a_in_side && pc_rise[4] && grp_a_in_full
        && input_irq_mask && !cw_wr |=> irq_in_pend ##1 pc_o[3])
        else $error("input request not raised");
    irq_or_a: assert property (a_mode == SBP_A_BIDIR && !cw_wr |=> pc_o[3] ==
        $past((irq_in_pend && input_irq_mask) || (irq_out_pend && output_irq_mask)))
        else $error("bidir request is not the OR of both sides");
    cw_clear_a: assert property (cw_wr |=> pa_latch == 8'h00 && pc_latch == 8'h00)
        else $error("latches not cleared by mode set");
    stat_rd_a: assert property (rd_fire && ra == AW'(`SBP_OFS_PORT_C)
        && a_mode == SBP_A_BIDIR |=> s_axi_rdata_o[7:3] == $past({grp_a_out_full_n,
        output_irq_mask, grp_a_in_full, input_irq_mask, irq_a}))
        else $error("bidir status read layout wrong");

    out_xfer_c: cover property (wr_a && a_mode == SBP_A_BIDIR ##[1:50] pc_fall[6]);
    in_xfer_c: cover property (a_mode == SBP_A_BIDIR && pc_fall[4] ##[1:50] rd_a);
    irq_c: cover property (a_mode == SBP_A_BIDIR && irq_a);
endmodule

//--- sbp_sync_edge.sv
// two-flop synchroniser with edge detection for a vector of pins
`timescale 1ns/10ps
module sbp_sync_edge #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] lvl_o,
    output logic [WIDTH-1:0] fall_o,
    output logic [WIDTH-1:0] rise_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;
    logic [WIDTH-1:0] next_prev;

    if (WIDTH < 1) begin : g_chk
        $error("sbp_sync_edge: WIDTH must be at least 1");
    end

    // shift chain; meta feeds only sync
    always_comb begin
        next_meta = d_i;
        next_sync = meta;
        next_prev = sync;
    end

    // idle high: strobe lines are active low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '1;
            sync <= '1;
            prev <= '1;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // edges flagged in the same cycle the synchronised level changes
    assign lvl_o = sync;
    assign fall_o = prev & ~sync;
    assign rise_o = ~prev & sync;
endmodule

//--- strobed_bidir_parallel_port_bench.sv
// self-checking bench of the strobed parallel port
`timescale 1ns/10ps
module strobed_bidir_parallel_port_bench;
    logic mclk_i = 0, sys_rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_bready_i = 0, s_axi_rready_i = 0;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, seed = 8'h53, x, y;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic [7:0] pa_i, pa_o, pb_o, pc_o, pc_oe_o, pc_i, pb_i = 8'h3C;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, pa_oe_o, pb_oe_o, ret_n, strobe_n;
    logic [9:0] q[$];
    logic [1:0] bq[$];
    int bad_count = 0, check_count = 0, cyc = 0;
    // port C has pull-ups; peripheral owns return and both group strobes
    assign pc_i = (pc_o | ~pc_oe_o) & {1'b1, ret_n, 1'b1, strobe_n, 1'b1, strobe_n, 2'h3};
    sbp_port_top uut (.mclk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
        .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .pa_i, .pa_o, .pa_oe_o, .pb_i, .pb_o, .pb_oe_o, .pc_i, .pc_o, .pc_oe_o);
    sbp_periph p (.mclk_i, .dev_pa_i(pa_o), .dev_pa_oe_i(pa_oe_o), .pa_pin_o(pa_i),
        .ret_n_o(ret_n), .strobe_n_o(strobe_n));
    initial forever #20 mclk_i = ~mclk_i;
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bq.push_back((a < 8'h10) ? 2'h0 : 2'h2);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h000000, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        s_axi_bready_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [9:0] e);
        q.push_back(e);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        s_axi_rready_i <= 1'b0;
    endtask
    // read results against the oldest note; watchdog cuts hangs
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (s_axi_rvalid_o && s_axi_rready_i)
            chk("read", q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o[7:0]});
        if (s_axi_bvalid_o && s_axi_bready_i)
            chk("bresp", {8'h00, bq.pop_front()}, {8'h00, s_axi_bresp_o});
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(8'h0C, 10'h09B);
        wr(8'h0C, 8'h80);
        seed = nx(seed);
        wr(8'h04, seed);
        wr(8'h0C, 8'h80);
        repeat (2) @(posedge mclk_i);
        chk("pb_o", 10'h000, {2'h0, pb_o});
        $display("test clear done");
        wr(8'h0C, 8'hC0);
        wr(8'h0C, 8'h0D);
        wr(8'h0C, 8'h09);
        seed = nx(seed);
        x = seed;
        wr(8'h00, x);
        repeat (8) @(posedge mclk_i);
        chk("out_full_n", 10'h000, pc_o[7]);
        chk("pa_oe", 10'h000, pa_oe_o);
        p.take(y);
        chk("pa_pins", {2'h0, x}, {2'h0, y});
        chk("out_full_n", 10'h001, pc_o[7]);
        chk("irq", 10'h001, pc_o[3]);
        wr(8'h00, x);
        repeat (2) @(posedge mclk_i);
        chk("irq", 10'h000, pc_o[3]);
        $display("test output done");
        seed = nx(seed);
        y = seed;
        p.put(y);
        repeat (4) @(posedge mclk_i);
        chk("in_full", 10'h001, pc_o[5]);
        chk("irq", 10'h001, pc_o[3]);
        rd(8'h08, 10'h078);
        rd(8'h00, {2'h0, y});
        repeat (2) @(posedge mclk_i);
        chk("in_full", 10'h000, {pc_o[5], pc_o[3]});
        wr(8'h08, seed);
        rd(8'h08, {2'h0, 8'h50 | (seed & 8'h07)});
        wr(8'h0C, 8'h03);
        rd(8'h08, {2'h0, 8'h52 | (seed & 8'h07)});
        rd(8'h10, 10'h200);
        wr(8'h10, 8'h00);
        $display("test input done");
        wr(8'h0C, 8'h86);
        wr(8'h0C, 8'h05);
        seed = nx(seed);
        pb_i <= seed;
        p.put(~seed);
        repeat (4) @(posedge mclk_i);
        rd(8'h08, 10'h007);
        rd(8'h04, {2'h0, seed});
        $display("test group b done");
        sys_rst_i <= 1'b1;
        repeat (13) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        chk("oe", 10'h000, {pa_oe_o, pb_oe_o, pc_oe_o});
        rd(8'h0C, 10'h09B);
        $display("test reset done");
        finish_test();
    end
endmodule
